//--- hdl/serial_host_control_port.v
// Purpose: Serial control port, SPI or I2C, master or slave, with receive FIFO
// Assumes: All link pins are asynchronous to ref_clk and sampled through two flops
// Notes:   Slave-side link levels must each last two ref_clk cycles to be seen
`timescale 1ns/1ps
`include "scp_consts.vh"

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             nrst,
  // Fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  localparam [AW:0] FULL = DEPTH[AW:0];

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    rd_ptr_r;
  reg  [AW:0]      count_r;
  wire             push;
  wire             pop;

  assign in_ready  = (count_r != FULL);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap naturally, so DEPTH must be a power of two
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end
endmodule // byte_fifo

module serial_host_control_port #(
  parameter [6:0]  I2C_SLAVE_ADDR = 7'h40,
  parameter [6:0]  EE_I2C_ADDR    = 7'h50,
  parameter [23:0] BOOT_ADDR      = 24'h00_0000,
  parameter        FIFO_DEPTH     = 16,
  parameter        FIFO_AW        = 4
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       nrst,
  // Mode straps
  input  wire [1:0] mode_sel,
  // Serial clock pin, SPI SCK or I2C SCL
  input  wire       sck_i,
  output wire       sck_o,
  output wire       sck_oe,
  // SPI chip select pin
  input  wire       cs_n_i,
  output wire       cs_n_o,
  output wire       cs_n_oe,
  // SPI data pins
  input  wire       mosi_i,
  output wire       mosi_o,
  output wire       mosi_oe,
  input  wire       miso_i,
  output wire       miso_o,
  output wire       miso_oe,
  // I2C data pin, open drain
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe,
  // Received bytes to the core
  output wire [7:0] rx_data,
  output wire       rx_valid,
  input  wire       rx_ready,
  // Message byte from the core
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output wire       tx_ready,
  // Boot fetch control and role status
  input  wire       boot_run,
  output wire       mode_is_master,
  output wire       mode_is_i2c,
  // Flow control and message flag
  output wire       port_flow_hold,
  output wire       host_message_request
);
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_START = 8'h02;
  localparam [7:0] S_ADDR  = 8'h04;
  localparam [7:0] S_ACK   = 8'h08;
  localparam [7:0] S_WR    = 8'h10;
  localparam [7:0] S_RD    = 8'h20;
  localparam [7:0] S_RACK  = 8'h40;
  localparam [7:0] S_STOP  = 8'h80;
  localparam integer SPI_RELOAD_I = `SPI_HALF_CYC - 1;
  localparam integer I2C_RELOAD_I = `I2C_QTR_CYC - 1;
  localparam [7:0]   SPI_RELOAD   = SPI_RELOAD_I[7:0];
  localparam [7:0]   I2C_RELOAD   = I2C_RELOAD_I[7:0];

  reg  [6:0] sync1_r;
  reg  [6:0] sync2_r;
  reg  [2:0] prev_r;
  reg  [1:0] strap_cnt_r;
  reg        strap_done_r;
  reg  [1:0] mode_r;
  reg  [7:0] state_r;
  reg  [3:0] cnt_r;
  reg  [7:0] shreg_r;
  reg  [7:0] out_sr_r;
  reg  [2:0] hdr_r;
  reg  [1:0] q_r;
  reg  [7:0] div_r;
  reg        sck_r;
  reg        cs_r;
  reg        scl_low_r;
  reg        sda_low_r;
  reg        ack_r;
  reg        ack_drv_r;
  reg        rw_r;
  reg        wr_r;
  reg        push_r;
  reg  [7:0] push_data_r;
  reg        tx_full_r;
  reg  [7:0] tx_byte_r;
  wire       fifo_in_ready;
  wire       sck_s  = sync2_r[0];
  wire       cs_s   = sync2_r[1];
  wire       mosi_s = sync2_r[2];
  wire       miso_s = sync2_r[3];
  wire       sda_s  = sync2_r[4];
  wire       sck_rise = sck_s & ~prev_r[0];
  wire       sck_fall = ~sck_s & prev_r[0];
  wire       cs_fall  = ~cs_s & prev_r[1];
  wire       start_c  = sck_s & prev_r[0] & ~sda_s & prev_r[2];
  wire       stop_c   = sck_s & prev_r[0] & sda_s & ~prev_r[2];
  wire       tick     = (div_r == 8'h00);
  wire [7:0] idle_byte = mode_r[`MODE_I2C_BIT] ? `I2C_IDLE_BYTE : `SPI_IDLE_BYTE;
  wire [7:0] load_byte = tx_full_r ? tx_byte_r : idle_byte;
  wire       act    = strap_done_r;
  wire       spi_m  = act & mode_r[`MODE_MASTER_BIT] & ~mode_r[`MODE_I2C_BIT];
  wire       spi_s  = act & ~mode_r[`MODE_MASTER_BIT] & ~mode_r[`MODE_I2C_BIT];
  wire       i2c_m  = act & mode_r[`MODE_MASTER_BIT] & mode_r[`MODE_I2C_BIT];
  wire       i2c_s  = act & ~mode_r[`MODE_MASTER_BIT] & mode_r[`MODE_I2C_BIT];

  function [7:0] hdr_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    hdr_byte = `SPI_CMD_READ;
        3'h1:    hdr_byte = BOOT_ADDR[23:16];
        3'h2:    hdr_byte = BOOT_ADDR[15:8];
        3'h3:    hdr_byte = BOOT_ADDR[7:0];
        default: hdr_byte = `SPI_IDLE_BYTE;
      endcase
    end
  endfunction

  assign sck_o   = spi_m & sck_r;
  assign sck_oe  = spi_m | (i2c_m & scl_low_r);
  assign cs_n_o  = cs_r;
  assign cs_n_oe = spi_m;
  assign mosi_o  = out_sr_r[7];
  assign mosi_oe = spi_m;
  assign miso_o  = out_sr_r[7];
  assign miso_oe = spi_s & ~cs_s;
  assign sda_o   = 1'b0;
  assign sda_oe  = (i2c_m | i2c_s) & sda_low_r;
  assign mode_is_master = mode_r[`MODE_MASTER_BIT];
  assign mode_is_i2c    = mode_r[`MODE_I2C_BIT];
  assign port_flow_hold = ~strap_done_r | ~fifo_in_ready;
  assign host_message_request = tx_full_r;
  assign tx_ready = ~tx_full_r;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_data   (push_data_r),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r      <= 7'h00;
      sync2_r      <= 7'h00;
      prev_r       <= 3'h0;
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
      mode_r       <= 2'h0;
    end else begin
      sync1_r <= {mode_sel, sda_i, miso_i, mosi_i, cs_n_i, sck_i};
      sync2_r <= sync1_r;
      prev_r  <= {sync2_r[4], sync2_r[1], sync2_r[0]};
      if (!strap_done_r) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        if (strap_cnt_r == `STRAP_LATCH_CNT) begin
          mode_r       <= sync2_r[6:5];
          strap_done_r <= 1'b1;
        end
      end
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE; cnt_r <= 4'h0; shreg_r <= 8'h00; out_sr_r <= 8'h00;
      hdr_r <= 3'h0; q_r <= 2'h0; div_r <= 8'h00; sck_r <= 1'b0; cs_r <= 1'b1;
      scl_low_r <= 1'b0; sda_low_r <= 1'b0; ack_r <= 1'b0; ack_drv_r <= 1'b0;
      rw_r <= 1'b0; wr_r <= 1'b0; push_r <= 1'b0; push_data_r <= 8'h00;
      tx_full_r <= 1'b0; tx_byte_r <= 8'h00;
    end else begin
      push_r <= 1'b0;
      // Divider keeps SCK at or below half the core clock
      div_r <= tick ? (mode_r[`MODE_I2C_BIT] ? I2C_RELOAD : SPI_RELOAD) : div_r - 8'h01;
      if (spi_s) begin
        if (cs_s) begin
          cnt_r <= 4'h0;
        end else if (cs_fall) begin
          out_sr_r <= load_byte;
          tx_full_r <= 1'b0;
        end else if (sck_rise) begin
          shreg_r <= {shreg_r[6:0], mosi_s};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h7) begin
            cnt_r <= 4'h0;
            // Byte lost if the host ignored busy
            push_r <= 1'b1;
            push_data_r <= {shreg_r[6:0], mosi_s};
            out_sr_r <= load_byte;
            tx_full_r <= 1'b0;
          end
        end else if (sck_fall && cnt_r != 4'h0) begin
          out_sr_r <= {out_sr_r[6:0], 1'b0};
        end
      end else if (spi_m) begin
        if (state_r == S_IDLE) begin
          cs_r <= 1'b1;
          sck_r <= 1'b0;
          if (boot_run) begin
            state_r <= S_WR; cs_r <= 1'b0; hdr_r <= 3'h0; cnt_r <= 4'h0;
            out_sr_r <= hdr_byte(3'h0);
          end
        end else if (tick) begin
          if (!sck_r) begin
            // Stall at byte start while the FIFO has no room
            if (cnt_r == 4'h0 && hdr_r == `SPI_HDR_BYTES && !(fifo_in_ready && boot_run)) begin
              if (!boot_run) begin
                state_r <= S_IDLE;
                cs_r <= 1'b1;
              end
            end else begin
              sck_r <= 1'b1;
              cnt_r <= cnt_r + 4'h1;
            end
          end else begin
            sck_r <= 1'b0;
            // Sample late: a bit launched on the last fall needs the sync delay
            shreg_r <= {shreg_r[6:0], miso_s};
            if (cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (hdr_r == `SPI_HDR_BYTES) begin
                push_r <= 1'b1;
                push_data_r <= {shreg_r[6:0], miso_s};
              end else begin
                hdr_r <= hdr_r + 3'h1;
              end
              out_sr_r <= hdr_byte(hdr_r + 3'h1);
            end else begin
              out_sr_r <= {out_sr_r[6:0], 1'b0};
            end
          end
        end
      end else if (i2c_s) begin
        if (start_c) begin
          state_r <= S_ADDR; cnt_r <= 4'h0; sda_low_r <= 1'b0;
        end else if (stop_c) begin
          state_r <= S_IDLE; sda_low_r <= 1'b0;
        end else begin
          case (state_r)
            S_ADDR, S_WR: if (sck_rise) begin
              shreg_r <= {shreg_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7) begin
                cnt_r <= 4'h0; state_r <= S_ACK; ack_drv_r <= 1'b0;
                if (state_r == S_ADDR) begin
                  ack_r <= (shreg_r[6:0] == I2C_SLAVE_ADDR);
                  rw_r <= sda_s;
                end else begin
                  ack_r <= fifo_in_ready;
                  push_r <= fifo_in_ready;
                  push_data_r <= {shreg_r[6:0], sda_s};
                end
              end
            end
            S_ACK: if (sck_fall) begin
              if (!ack_drv_r) begin
                ack_drv_r <= 1'b1; sda_low_r <= ack_r;
              end else begin
                ack_drv_r <= 1'b0; sda_low_r <= 1'b0;
                if (!ack_r) begin
                  state_r <= S_IDLE;
                end else if (rw_r) begin
                  state_r <= S_RD; out_sr_r <= load_byte; tx_full_r <= 1'b0; sda_low_r <= ~load_byte[7];
                end else begin
                  state_r <= S_WR;
                end
              end
            end
            S_RD: if (sck_rise) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7) begin
                state_r <= S_RACK; cnt_r <= 4'h0; ack_drv_r <= 1'b0;
              end
            end else if (sck_fall && cnt_r != 4'h0) begin
              out_sr_r <= {out_sr_r[6:0], 1'b1}; sda_low_r <= ~out_sr_r[6];
            end
            S_RACK: if (sck_fall && !ack_drv_r) begin
              sda_low_r <= 1'b0;
            end else if (sck_rise) begin
              if (sda_s) state_r <= S_IDLE;
              else ack_drv_r <= 1'b1;
            end else if (sck_fall) begin
              state_r <= S_RD; ack_drv_r <= 1'b0;
              out_sr_r <= load_byte; tx_full_r <= 1'b0; sda_low_r <= ~load_byte[7];
            end
            default: state_r <= S_IDLE;
          endcase
        end
      end else if (i2c_m && tick) begin
        case (state_r)
          S_IDLE: begin
            scl_low_r <= 1'b0; sda_low_r <= 1'b0; q_r <= 2'h0;
            if (boot_run) state_r <= S_START;
          end
          S_START: begin
            q_r <= q_r + 2'h1;
            if (q_r == 2'h1) sda_low_r <= 1'b1;
            if (q_r == 2'h2) scl_low_r <= 1'b1;
            if (q_r == 2'h3) begin
              state_r <= S_RD; cnt_r <= 4'h0; wr_r <= 1'b1; out_sr_r <= {EE_I2C_ADDR, 1'b1};
            end
          end
          S_RD: case (q_r)
            2'h0: if (!(cnt_r == 4'h0 && !wr_r && !fifo_in_ready)) begin
              q_r <= 2'h1;
              sda_low_r <= wr_r ? (cnt_r != 4'h8 && !out_sr_r[7]) : (cnt_r == 4'h8 && ack_r);
            end
            2'h1: begin
              scl_low_r <= 1'b0; q_r <= 2'h2;
            end
            2'h2: begin
              q_r <= 2'h3;
              if (cnt_r != 4'h8) shreg_r <= {shreg_r[6:0], sda_s};
              if (cnt_r == 4'h7 && !wr_r) begin
                push_r <= 1'b1; push_data_r <= {shreg_r[6:0], sda_s}; ack_r <= boot_run;
              end
              if (cnt_r == 4'h8 && wr_r) ack_r <= ~sda_s;
            end
            default: begin
              scl_low_r <= 1'b1; q_r <= 2'h0;
              out_sr_r <= {out_sr_r[6:0], 1'b1};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h8) begin
                cnt_r <= 4'h0; wr_r <= 1'b0;
                if (!ack_r) state_r <= S_STOP;
              end
            end
          endcase
          S_STOP: begin
            q_r <= q_r + 2'h1;
            if (q_r == 2'h0) sda_low_r <= 1'b1;
            if (q_r == 2'h1) scl_low_r <= 1'b0;
            if (q_r == 2'h2) sda_low_r <= 1'b0;
            if (q_r == 2'h3) state_r <= S_IDLE;
          end
          default: state_r <= S_IDLE;
        endcase
      end
      // Taken last so a new byte beats a same-cycle clear of the empty slot
      if (tx_valid && !tx_full_r) begin
        tx_full_r <= 1'b1;
        tx_byte_r <= tx_data;
      end
    end
  end
endmodule // serial_host_control_port

//--- hdl/scp_consts.vh
// Purpose: Shared constants of the serial host control port
// Assumes: Core clock ref_clk at REF_CLK_MHZ
// Notes:   SCK and I2C timing counts are derived here; only STRAP_LATCH_CNT is typed as a cycle figure
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

`define REF_CLK_MHZ      100
`define SPI_SCK_MAX_MHZ  25
// Half SCK period in core cycles, rounded up so SCK stays at or below both limits
`define SPI_HALF_CYC     ((`REF_CLK_MHZ + 2 * `SPI_SCK_MAX_MHZ - 1) / (2 * `SPI_SCK_MAX_MHZ))
`define I2C_LOW_NS       1250
// Quarter of an I2C bit; two quarters make the low time, rounded up
`define I2C_QTR_CYC      ((`I2C_LOW_NS * `REF_CLK_MHZ + 1999) / 2000)

`define MODE_MASTER_BIT  0
`define MODE_I2C_BIT     1
`define STRAP_LATCH_CNT  2'h2
`define SPI_CMD_READ     8'h03
`define SPI_HDR_BYTES    3'h4
`define SPI_IDLE_BYTE    8'h00
`define I2C_IDLE_BYTE    8'hff

`endif

//--- tb/scp_checker_sva.sv
// Purpose: Port assertions for the serial host control port
// Assumes: Straps held steady for a few cycles after reset release
// Notes:   Counter margins allow for the strap synchroniser delay
`timescale 1ns/1ps
module scp_checker (
  // Clock and reset
  input wire       ref_clk,
  input wire       nrst,
  // Straps and role
  input wire [1:0] mode_sel,
  input wire       mode_is_master,
  input wire       mode_is_i2c,
  // Pins
  input wire       sck_o,
  input wire       sck_oe,
  input wire       cs_n_oe,
  input wire       mosi_oe,
  input wire       miso_oe,
  input wire       sda_o,
  input wire       sda_oe,
  // Core side
  input wire       rx_valid,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       port_flow_hold,
  input wire       host_message_request
);
  reg  [2:0] since_rst_r;
  wire [2:0] since_rst_nxt = (since_rst_r == 3'h7) ? since_rst_r : since_rst_r + 3'h1;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) since_rst_r <= 3'h0;
    else since_rst_r <= since_rst_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_strap_take;
    since_rst_r == 3'h5 |-> mode_is_master == mode_sel[0] && mode_is_i2c == mode_sel[1];
  endproperty
  a_strap_take: assert property (p_strap_take) else $error("strap not taken");
  property p_strap_keep;
    since_rst_r == 3'h7 |-> $stable(mode_is_master) && $stable(mode_is_i2c);
  endproperty
  a_strap_keep: assert property (p_strap_keep) else $error("role changed");
  property p_hold_latch;
    since_rst_r < 3'h2 |-> port_flow_hold;
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("hold low too early");
  property p_hold_full;
    port_flow_hold && since_rst_r == 3'h7 |-> rx_valid;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("hold with empty fifo");
  property p_req_set;
    tx_valid && tx_ready |=> host_message_request;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request not set");
  property p_req_full;
    host_message_request |-> !tx_ready;
  endproperty
  a_req_full: assert property (p_req_full) else $error("tx ready while pending");
  property p_sck_high;
    $rose(sck_o) && sck_oe && !mode_is_i2c |=> sck_o;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("sck high too short");
  property p_slave_quiet;
    !mode_is_master |-> !sck_oe && !cs_n_oe && !mosi_oe;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives master pins");
  property p_miso_slave;
    miso_oe |-> !mode_is_master && !mode_is_i2c;
  endproperty
  a_miso_slave: assert property (p_miso_slave) else $error("miso driven off role");
  property p_sda_open;
    sda_oe |-> !sda_o && mode_is_i2c;
  endproperty
  a_sda_open: assert property (p_sda_open) else $error("sda driven off role");
endmodule // scp_checker
bind serial_host_control_port scp_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .mode_sel(mode_sel),
  .mode_is_master(mode_is_master), .mode_is_i2c(mode_is_i2c), .sck_o(sck_o), .sck_oe(sck_oe),
  .cs_n_oe(cs_n_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .sda_o(sda_o), .sda_oe(sda_oe),
  .rx_valid(rx_valid), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .port_flow_hold(port_flow_hold), .host_message_request(host_message_request));

//--- tb/scp_far_end.sv
// Purpose: Far end of the link, SPI host or SPI boot flash
// Assumes: Host SCK runs at 8 MHz, only inside frames
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
module scp_far_end (
  // Role
  input  wire        host_mode,
  // Resolved link lines
  input  wire        dev_sck,
  input  wire        dev_cs_n,
  input  wire        dev_mosi,
  input  wire        miso_o,
  input  wire        miso_oe,
  // Lines driven here
  output reg         sck,
  output reg         cs_n,
  output reg         mosi,
  output reg         miso,
  output reg  [31:0] hdr
);
  reg [15:0] bits;
  reg [7:0]  d;
  reg        last;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    miso = 1'b0;
    last = 1'b0;
    bits = 16'h0000;
    hdr = 32'h0000_0000;
  end
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      cs_n = 1'b0;
      #100;
      for (i = 7; i >= 0; i = i - 1) begin
        mosi = tx[i];
        #62.5 sck = 1'b1;
        rx[i] = miso_oe ? miso_o : ~last;
        last = rx[i];
        #62.5 sck = 1'b0;
      end
      #100 cs_n = 1'b1;
      mosi = ~mosi;
      #100;
    end
  endtask
  always @(negedge dev_cs_n) if (!host_mode) bits = 16'h0000;
  always @(posedge dev_sck) if (!host_mode && !dev_cs_n) begin
    if (bits < 16'h0020) hdr = {hdr[30:0], dev_mosi};
    bits = bits + 16'h0001;
  end
  // Flash data, changes on falling SCK
  always @(negedge dev_sck) if (!host_mode && !dev_cs_n && bits >= 16'h0020) begin
    d = (bits[10:3] - 8'h04) ^ 8'ha5;
    miso = d[~bits[2:0]];
  end
  always @(posedge dev_cs_n) if (!host_mode) miso = ~miso;
endmodule // scp_far_end

//--- tb/serial_host_control_port_tb.sv
// Purpose: Self-checking bench for the serial host control port
// Assumes: Far end model and bound checker
// Notes:   SPI roles in depth; I2C slave write and refusal; I2C master at START level
`timescale 1ns/1ps
`include "scp_consts.vh"
module serial_host_control_port_tb;
  localparam [6:0] SLV = 7'h40;
  reg         ref_clk, nrst, rx_ready, tx_valid, boot_run, host_mode;
  reg         scl_drv, sda_drv, scl_pull, ack;
  reg  [1:0]  mode_sel;
  reg  [7:0]  tx_data, got;
  reg  [31:0] seed;
  reg  [7:0]  q[$];
  integer     mismatches, comparisons, i, n;
  wire        sck_o, sck_oe, cs_n_o, cs_n_oe, mosi_o, mosi_oe, miso_o, miso_oe, sda_o, sda_oe;
  wire        rx_valid, tx_ready, mode_is_master, mode_is_i2c, port_flow_hold, host_message_request;
  wire        f_sck, f_cs_n, f_mosi, f_miso;
  wire [7:0]  rx_data;
  wire [31:0] hdr;
  wire        sck_i  = sck_oe ? sck_o : (scl_pull ? scl_drv : f_sck);
  wire        sda_line = sda_oe ? 1'b0 : sda_drv;
  wire        cs_n_i = cs_n_oe ? cs_n_o : f_cs_n;
  wire        mosi_i = mosi_oe ? mosi_o : f_mosi;
  serial_host_control_port #(.I2C_SLAVE_ADDR(SLV)) DUT (.ref_clk(ref_clk), .nrst(nrst), .mode_sel(mode_sel),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .cs_n_i(cs_n_i), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe),
    .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(f_miso), .miso_o(miso_o), .miso_oe(miso_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .boot_run(boot_run),
    .mode_is_master(mode_is_master), .mode_is_i2c(mode_is_i2c), .port_flow_hold(port_flow_hold),
    .host_message_request(host_message_request));
  scp_far_end far (.host_mode(host_mode), .dev_sck(sck_i), .dev_cs_n(cs_n_i), .dev_mosi(mosi_i),
    .miso_o(miso_o), .miso_oe(miso_oe), .sck(f_sck), .cs_n(f_cs_n), .mosi(f_mosi), .miso(f_miso), .hdr(hdr));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // I2C host bit: data while SCL low, line sampled at the end of SCL high
  task i2c_bit(input b, output s);
    begin
      sda_drv <= b;
      repeat (20) @(posedge ref_clk);
      scl_drv <= 1'b1;
      repeat (20) @(posedge ref_clk);
      s = sda_line;
      scl_drv <= 1'b0;
      repeat (20) @(posedge ref_clk);
    end
  endtask
  task i2c_byte(input [7:0] b, output s);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) i2c_bit(b[k], s);
      i2c_bit(1'b1, s);
    end
  endtask
  task do_reset(input [1:0] m);
    begin
      nrst <= 1'b0;
      mode_sel <= m;
      boot_run <= 1'b0;
      rx_ready <= 1'b0;
      host_mode = (m == 2'b00);
      scl_pull = m[1];
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("mode_is_master", m[0], mode_is_master);
      chk("mode_is_i2c", m[1], mode_is_i2c);
    end
  endtask
  // Oldest expected byte against each byte taken from the port
  always @(posedge ref_clk) if (nrst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
    if (q.size() > 0) chk("rx_data", q.pop_front(), rx_data);
    else chk("rx_extra", 0, 1);
  end
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #600_000;
    mismatches = mismatches + 1;
    finish_test;
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    mode_sel = 2'b00;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    boot_run = 1'b0;
    host_mode = 1'b1;
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    scl_pull = 1'b0;
    mismatches = 0;
    comparisons = 0;
    seed = 32'h5c28_0afe;
    do_reset(2'b00);
    chk("hold", 0, port_flow_hold);
    seed = lfsr(seed);
    mode_sel <= 2'b11;
    tx_data <= seed[7:0];
    tx_valid <= 1'b1;
    @(posedge ref_clk) tx_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("request", 1, host_message_request);
    // Seventeenth byte is sent into a full FIFO on purpose
    for (i = 0; i < 17; i = i + 1) begin
      seed = lfsr(seed);
      if (i < 16) chk("hold", 0, port_flow_hold);
      if (i < 16) q.push_back(seed[15:8]);
      far.xfer(seed[15:8], got);
      chk("miso_byte", (i == 0) ? tx_data : `SPI_IDLE_BYTE, got);
    end
    #1 chk("hold", 1, port_flow_hold);
    chk("request", 0, host_message_request);
    chk("mode_is_master", 0, mode_is_master);
    for (n = 0; q.size() > 0 && n < 2000; n = n + 1) begin
      @(posedge ref_clk) seed = lfsr(seed);
      rx_ready <= seed[0];
    end
    repeat (4) @(posedge ref_clk);
    #1 chk("hold", 0, port_flow_hold);
    chk("rx_left", 0, q.size());
    do_reset(2'b01);
    for (i = 0; i < 40; i = i + 1) q.push_back(i[7:0] ^ 8'ha5);
    boot_run <= 1'b1;
    for (n = 0; q.size() > 20 && n < 20000; n = n + 1) begin
      @(posedge ref_clk) seed = lfsr(seed);
      rx_ready <= seed[0] & seed[1];
    end
    chk("boot_rx", 1, q.size() <= 20);
    @(posedge ref_clk) rx_ready <= 1'b0;
    boot_run <= 1'b0;
    for (n = 0; cs_n_i !== 1'b1 && n < 2000; n = n + 1) @(posedge ref_clk);
    #1 chk("boot_cs", 1, cs_n_i);
    chk("boot_hdr", {`SPI_CMD_READ, 24'h00_0000}, hdr);
    q.delete();
    do_reset(2'b10);
    // Own address acked and its byte stored; a foreign address is refused
    for (n = 0; n < 2; n = n + 1) begin
      seed = lfsr(seed);
      sda_drv <= 1'b0;
      repeat (20) @(posedge ref_clk);
      scl_drv <= 1'b0;
      repeat (20) @(posedge ref_clk);
      i2c_byte({(n == 0) ? SLV : ~SLV, 1'b0}, ack);
      chk("i2c_addr_ack", n, ack);
      if (n == 0) begin
        q.push_back(seed[7:0]);
        i2c_byte(seed[7:0], ack);
        chk("i2c_data_ack", 0, ack);
      end
      sda_drv <= 1'b0;
      repeat (20) @(posedge ref_clk);
      scl_drv <= 1'b1;
      repeat (20) @(posedge ref_clk);
      sda_drv <= 1'b1;
      repeat (20) @(posedge ref_clk);
    end
    rx_ready <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("i2c_rx_left", 0, q.size());
    do_reset(2'b11);
    boot_run <= 1'b1;
    for (n = 0; !(sda_oe === 1'b1 && sck_oe === 1'b0) && n < 1000; n = n + 1) @(posedge ref_clk);
    #1 chk("i2c_start", 1, sda_oe & ~sck_oe);
    finish_test;
  end
endmodule // serial_host_control_port_tb
